// ===== rtl/ipv4_acl_entry_matcher.sv
// Top of one IPv4 access control entry: APB registers and hit decision.
// Assumes one header per in_valid pulse; result one cycle later.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ipv4_acl_entry_matcher #(
	parameter int IP_W = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame header
	input wire logic in_valid,
	input wire logic in_is_ipv4,
	input wire logic [7:0] in_protocol,
	input wire logic [7:0] in_ttl,
	input wire logic in_more_frags,
	input wire logic [12:0] in_frag_offset,
	input wire logic [3:0] in_header_len,
	input wire logic in_l4_match,
	input wire logic [IP_W-1:0] in_src_addr,
	input wire logic [IP_W-1:0] in_dst_addr,
	// Result
	output logic out_valid,
	output logic out_hit
);
	// Elaboration-time refusal of address widths other than IPv4
	if (IP_W != 32) begin : g_ip_w_check
		$error("IP_W must be 32 for IPv4 addresses");
	end

	acl_cfg_if cfg_bus();

	// Registers
	logic [31:0] ctrl, next_ctrl;
	logic [IP_W-1:0] src_addr, next_src_addr;
	logic [IP_W-1:0] src_mask, next_src_mask;
	logic [IP_W-1:0] dst_addr, next_dst_addr;
	logic [IP_W-1:0] dst_mask, next_dst_mask;
	logic [31:0] hit_cnt, next_hit_cnt;
	logic [31:0] frame_cnt, next_frame_cnt;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_out_valid;
	logic next_out_hit;
	logic wr_en;
	logic mapped;
	logic hdr_ok;
	logic src_ok;
	logic dst_ok;
	logic entry_is_ipv4;
	logic hit_now;

	assign entry_is_ipv4 = ctrl[acl_pkg::CTRL_TYPE];
	assign cfg_bus.proto_mode =
		acl_pkg::proto_mode_t'(ctrl[acl_pkg::CTRL_PROTO_LO +: 3]);
	assign cfg_bus.ttl_mode =
		acl_pkg::ttl_mode_t'(ctrl[acl_pkg::CTRL_TTL_LO +: 2]);
	assign cfg_bus.frag_mode =
		acl_pkg::flag_mode_t'(ctrl[acl_pkg::CTRL_FRAG_LO +: 2]);
	assign cfg_bus.opt_mode =
		acl_pkg::flag_mode_t'(ctrl[acl_pkg::CTRL_OPT_LO +: 2]);
	assign cfg_bus.proto_value = ctrl[acl_pkg::CTRL_PVAL_LO +: 8];

	ip_header_checker u_header (
		.cfg(cfg_bus.dst),
		.protocol(in_protocol),
		.ttl(in_ttl),
		.more_frags(in_more_frags),
		.frag_offset(in_frag_offset),
		.header_len(in_header_len),
		.l4_match(in_l4_match),
		.ok(hdr_ok)
	);

	ip_addr_matcher #(.IP_W(IP_W)) u_src (
		.mode(acl_pkg::addr_mode_t'(ctrl[acl_pkg::CTRL_SRC_LO +: 2])),
		.cfg_addr(src_addr),
		.cfg_mask(src_mask),
		.frame_addr(in_src_addr),
		.ok(src_ok)
	);

	ip_addr_matcher #(.IP_W(IP_W)) u_dst (
		.mode(acl_pkg::addr_mode_t'(ctrl[acl_pkg::CTRL_DST_LO +: 2])),
		.cfg_addr(dst_addr),
		.cfg_mask(dst_mask),
		.frame_addr(in_dst_addr),
		.ok(dst_ok)
	);

	// Non-IPv4 entry: IPv4 criteria left out, every frame hits
	always_comb begin
		if (entry_is_ipv4)
			hit_now = in_is_ipv4 && hdr_ok && src_ok && dst_ok;
		else
			hit_now = 1'b1;
	end

	// APB bus: one wait-free access cycle
	always_comb begin
		wr_en = psel && penable && pready && pwrite;
		next_pready = psel && !penable && !pready;
		mapped = 1'b1;
		next_prdata = 32'h0000_0000;
		if (paddr == acl_pkg::OFS_CTRL) begin
			next_prdata = ctrl;
		end else if (paddr == acl_pkg::OFS_SRC_ADDR) begin
			next_prdata = src_addr;
		end else if (paddr == acl_pkg::OFS_SRC_MASK) begin
			next_prdata = src_mask;
		end else if (paddr == acl_pkg::OFS_DST_ADDR) begin
			next_prdata = dst_addr;
		end else if (paddr == acl_pkg::OFS_DST_MASK) begin
			next_prdata = dst_mask;
		end else if (paddr == acl_pkg::OFS_HIT_CNT) begin
			next_prdata = hit_cnt;
		end else if (paddr == acl_pkg::OFS_FRAME_CNT) begin
			next_prdata = frame_cnt;
		end else if (paddr == acl_pkg::OFS_STATUS) begin
			next_prdata = {31'h0000_0000, out_hit};
		end else begin
			mapped = 1'b0;
		end
		if (!next_pready || pwrite)
			next_prdata = 32'h0000_0000;
		next_pslverr = next_pready && !mapped;
	end

	// Register writes and counters; each counter cleared by any write to its own offset
	always_comb begin
		next_ctrl = ctrl;
		next_src_addr = src_addr;
		next_src_mask = src_mask;
		next_dst_addr = dst_addr;
		next_dst_mask = dst_mask;
		next_hit_cnt = hit_cnt;
		next_frame_cnt = frame_cnt;
		if (in_valid) begin
			next_frame_cnt = frame_cnt + 32'h0000_0001;
			if (hit_now)
				next_hit_cnt = hit_cnt + 32'h0000_0001;
		end
		if (wr_en) begin
			if (paddr == acl_pkg::OFS_CTRL)
				next_ctrl = pwdata & acl_pkg::CTRL_WMASK;
			else if (paddr == acl_pkg::OFS_SRC_ADDR)
				next_src_addr = pwdata;
			else if (paddr == acl_pkg::OFS_SRC_MASK)
				next_src_mask = pwdata;
			else if (paddr == acl_pkg::OFS_DST_ADDR)
				next_dst_addr = pwdata;
			else if (paddr == acl_pkg::OFS_DST_MASK)
				next_dst_mask = pwdata;
			else if (paddr == acl_pkg::OFS_HIT_CNT)
				next_hit_cnt = 32'h0000_0000;
			else if (paddr == acl_pkg::OFS_FRAME_CNT)
				next_frame_cnt = 32'h0000_0000;
		end
		next_out_valid = in_valid;
		next_out_hit = in_valid ? hit_now : out_hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= acl_pkg::CTRL_RESET;
			src_addr <= '0;
			src_mask <= '0;
			dst_addr <= '0;
			dst_mask <= '0;
			hit_cnt <= 32'h0000_0000;
			frame_cnt <= 32'h0000_0000;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			out_valid <= 1'b0;
			out_hit <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			src_addr <= next_src_addr;
			src_mask <= next_src_mask;
			dst_addr <= next_dst_addr;
			dst_mask <= next_dst_mask;
			hit_cnt <= next_hit_cnt;
			frame_cnt <= next_frame_cnt;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			out_valid <= next_out_valid;
			out_hit <= next_out_hit;
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ipv4_frame;
		in_valid && entry_is_ipv4;
	endsequence

	a_type_gate: assert property (
		s_ipv4_frame and (!in_is_ipv4) |=> out_valid && !out_hit)
		else $error("non-IPv4 frame hit an IPv4 entry");

	a_proto_specific: assert property (
		s_ipv4_frame and (
		cfg_bus.proto_mode == acl_pkg::PROTO_SPECIFIC &&
		in_protocol != cfg_bus.proto_value) |=> !out_hit)
		else $error("protocol mismatch hit");

	a_proto_l4: assert property (
		s_ipv4_frame and (
		cfg_bus.proto_mode == acl_pkg::PROTO_SEL_TCP &&
		(in_protocol != acl_pkg::PROTO_TCP || !in_l4_match)) |=> !out_hit)
		else $error("TCP selection hit a non-TCP frame");

	a_ttl_zero: assert property (
		s_ipv4_frame and (cfg_bus.ttl_mode == acl_pkg::TTL_ZERO &&
		in_ttl != 8'h00) |=> !out_hit)
		else $error("nonzero TTL hit a zero-TTL entry");

	a_ttl_nonzero: assert property (
		s_ipv4_frame and (cfg_bus.ttl_mode == acl_pkg::TTL_NONZERO &&
		in_ttl == 8'h00) |=> !out_hit)
		else $error("zero TTL hit a nonzero-TTL entry");

	a_frag_no: assert property (
		s_ipv4_frame and (cfg_bus.frag_mode == acl_pkg::FLAG_NO &&
		in_more_frags) |=> !out_hit)
		else $error("fragment hit a no-fragment entry");

	a_frag_yes: assert property (
		s_ipv4_frame and (cfg_bus.frag_mode == acl_pkg::FLAG_YES &&
		!in_more_frags && in_frag_offset == 13'h0000) |=> !out_hit)
		else $error("whole frame hit a fragment entry");

	a_opt_yes: assert property (
		s_ipv4_frame and (cfg_bus.opt_mode == acl_pkg::FLAG_YES &&
		in_header_len <= acl_pkg::IHL_NO_OPTIONS) |=> !out_hit)
		else $error("frame without options hit an options entry");

	a_src_host: assert property (
		s_ipv4_frame and (
		ctrl[acl_pkg::CTRL_SRC_LO +: 2] == acl_pkg::ADDR_HOST &&
		in_src_addr != src_addr) |=> !out_hit)
		else $error("source host mismatch hit");

	a_dst_net: assert property (
		s_ipv4_frame and (
		ctrl[acl_pkg::CTRL_DST_LO +: 2] == acl_pkg::ADDR_NETWORK &&
		((in_dst_addr ^ dst_addr) & dst_mask) != '0) |=> !out_hit)
		else $error("destination network mismatch hit");

	// IPv4 entry with every criterion at any: an IPv4 frame must hit
	a_all_pass: assert property (
		s_ipv4_frame and (in_is_ipv4 && ctrl == 32'h0000_0001) |=>
		out_valid && out_hit)
		else $error("frame meeting all criteria missed");

	a_apb_answer: assert property (
		psel && !penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not a single cycle");
endmodule : ipv4_acl_entry_matcher

// ===== rtl/acl_pkg.sv
// Constants for the IPv4 access control entry matcher.
// Assumes an APB master on pclk and one frame header per valid pulse.
// Operation
// - IPv4 criteria apply only to IPv4 entries
// - Protocol any ignores protocol field
// - Protocol specific hits equal 8-bit value only
// - ICMP/UDP/TCP restrict and add layer-4 check
// - TTL zero excludes nonzero TTL; any ignores
// - TTL nonzero hits nonzero, misses zero TTL
// - Fragment no excludes fragments; any ignores
// - Fragment yes hits fragments only
// - Options no excludes frames with options
// - Options yes hits frames with options only
// - Source any ignores source address
// - Source host needs exact address equality
// - Source network compares masked bits only
// - Destination any ignores destination address
// - Destination host needs exact address equality
// - Destination network compares masked bits only
package acl_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC_ADDR = 8'h04;
	localparam logic [7:0] OFS_SRC_MASK = 8'h08;
	localparam logic [7:0] OFS_DST_ADDR = 8'h0c;
	localparam logic [7:0] OFS_DST_MASK = 8'h10;
	localparam logic [7:0] OFS_HIT_CNT = 8'h14;
	localparam logic [7:0] OFS_FRAME_CNT = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// Control field positions
	localparam int CTRL_TYPE = 0;
	localparam int CTRL_PROTO_LO = 1;
	localparam int CTRL_TTL_LO = 4;
	localparam int CTRL_FRAG_LO = 6;
	localparam int CTRL_OPT_LO = 8;
	localparam int CTRL_SRC_LO = 10;
	localparam int CTRL_DST_LO = 12;
	localparam int CTRL_PVAL_LO = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h00ff_3fff;
	// Protocol numbers and header length
	localparam logic [7:0] PROTO_ICMP = 8'h01;
	localparam logic [7:0] PROTO_TCP = 8'h06;
	localparam logic [7:0] PROTO_UDP = 8'h11;
	localparam logic [3:0] IHL_NO_OPTIONS = 4'h5;
	typedef enum logic [2:0] {
		PROTO_ANY = 3'h0, PROTO_SPECIFIC = 3'h1, PROTO_SEL_ICMP = 3'h2,
		PROTO_SEL_UDP = 3'h3, PROTO_SEL_TCP = 3'h4
	} proto_mode_t;
	typedef enum logic [1:0] {
		TTL_ANY = 2'h0, TTL_ZERO = 2'h1, TTL_NONZERO = 2'h2
	} ttl_mode_t;
	typedef enum logic [1:0] {
		FLAG_ANY = 2'h0, FLAG_NO = 2'h1, FLAG_YES = 2'h2
	} flag_mode_t;
	typedef enum logic [1:0] {
		ADDR_ANY = 2'h0, ADDR_HOST = 2'h1, ADDR_NETWORK = 2'h2
	} addr_mode_t;
endpackage : acl_pkg

// ===== rtl/acl_cfg_if.sv
// Entry configuration passed from the register file to the checker.
// Assumes a single driver through the src modport.
`timescale 1ns/1ps
interface acl_cfg_if;
	acl_pkg::proto_mode_t proto_mode;
	acl_pkg::ttl_mode_t ttl_mode;
	acl_pkg::flag_mode_t frag_mode;
	acl_pkg::flag_mode_t opt_mode;
	logic [7:0] proto_value;
	modport src (output proto_mode, ttl_mode, frag_mode, opt_mode,
		proto_value);
	modport dst (input proto_mode, ttl_mode, frag_mode, opt_mode,
		proto_value);
endinterface : acl_cfg_if

// ===== rtl/ip_addr_matcher.sv
// Address criterion: any, host or network with mask.
// Assumes configuration held stable while frames are checked.
`timescale 1ns/1ps
module ip_addr_matcher #(
	parameter int IP_W = 32
) (
	// Criterion
	input wire acl_pkg::addr_mode_t mode,
	input wire logic [IP_W-1:0] cfg_addr,
	input wire logic [IP_W-1:0] cfg_mask,
	// Frame field
	input wire logic [IP_W-1:0] frame_addr,
	output logic ok
);
	always_comb begin
		case (mode)
			acl_pkg::ADDR_HOST: ok = frame_addr == cfg_addr;
			acl_pkg::ADDR_NETWORK:
				ok = ((frame_addr ^ cfg_addr) & cfg_mask) == '0;
			default: ok = 1'b1;
		endcase
	end
endmodule : ip_addr_matcher

// ===== rtl/ip_header_checker.sv
// Protocol, TTL, fragment and options criteria of one entry.
// Assumes layer-4 result is computed outside for ICMP/UDP/TCP.
`timescale 1ns/1ps
module ip_header_checker (
	// Configuration
	acl_cfg_if.dst cfg,
	// Header fields
	input wire logic [7:0] protocol,
	input wire logic [7:0] ttl,
	input wire logic more_frags,
	input wire logic [12:0] frag_offset,
	input wire logic [3:0] header_len,
	input wire logic l4_match,
	output logic ok
);
	logic proto_ok;
	logic ttl_ok;
	logic frag_ok;
	logic opt_ok;
	logic is_frag;
	logic has_opt;

	always_comb begin
		is_frag = more_frags || frag_offset != 13'h0000;
		has_opt = header_len > acl_pkg::IHL_NO_OPTIONS;
		case (cfg.proto_mode)
			acl_pkg::PROTO_SPECIFIC: proto_ok = protocol == cfg.proto_value;
			acl_pkg::PROTO_SEL_ICMP:
				proto_ok = protocol == acl_pkg::PROTO_ICMP && l4_match;
			acl_pkg::PROTO_SEL_UDP:
				proto_ok = protocol == acl_pkg::PROTO_UDP && l4_match;
			acl_pkg::PROTO_SEL_TCP:
				proto_ok = protocol == acl_pkg::PROTO_TCP && l4_match;
			default: proto_ok = 1'b1;
		endcase
		case (cfg.ttl_mode)
			acl_pkg::TTL_ZERO: ttl_ok = ttl == 8'h00;
			acl_pkg::TTL_NONZERO: ttl_ok = ttl != 8'h00;
			default: ttl_ok = 1'b1;
		endcase
		case (cfg.frag_mode)
			acl_pkg::FLAG_NO: frag_ok = !is_frag;
			acl_pkg::FLAG_YES: frag_ok = is_frag;
			default: frag_ok = 1'b1;
		endcase
		case (cfg.opt_mode)
			acl_pkg::FLAG_NO: opt_ok = !has_opt;
			acl_pkg::FLAG_YES: opt_ok = has_opt;
			default: opt_ok = 1'b1;
		endcase
		ok = proto_ok && ttl_ok && frag_ok && opt_ok;
	end
endmodule : ip_header_checker

// ===== tb/frame_source.sv
// Frame header source standing in for the switch ingress pipeline.
// Assumes headers are taken on the rising edge of pclk.
`timescale 1ns/1ps
module frame_source (
	// Clock
	input wire logic pclk,
	// Header to matcher
	output logic in_valid,
	output logic in_is_ipv4,
	output logic [7:0] in_protocol,
	output logic [7:0] in_ttl,
	output logic in_more_frags,
	output logic [12:0] in_frag_offset,
	output logic [3:0] in_header_len,
	output logic in_l4_match,
	output logic [31:0] in_src_addr,
	output logic [31:0] in_dst_addr
);
	initial begin
		in_valid = 1'b0;
		{in_is_ipv4, in_protocol, in_ttl, in_more_frags, in_frag_offset,
			in_header_len, in_l4_match, in_src_addr, in_dst_addr} = '0;
	end

	task automatic send(input logic [99:0] h);
		@(posedge pclk);
		in_valid <= 1'b1;
		{in_is_ipv4, in_protocol, in_ttl, in_more_frags, in_frag_offset,
			in_header_len, in_l4_match, in_src_addr, in_dst_addr} <= h;
		@(posedge pclk);
		in_valid <= 1'b0;
		// Stale fields must not look valid
		{in_is_ipv4, in_protocol, in_ttl, in_more_frags, in_frag_offset,
			in_header_len, in_l4_match, in_src_addr, in_dst_addr} <= ~h;
	endtask : send
endmodule : frame_source

// ===== tb/ipv4_acl_entry_matcher_tb.sv
// Self-checking bench: APB configuration and one frame per test case.
// Assumes the frame_source model and the matcher top in rtl/.
`timescale 1ns/1ps
module ipv4_acl_entry_matcher_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic in_valid, in_is_ipv4, in_more_frags, in_l4_match, e;
	logic [7:0] in_protocol, in_ttl;
	logic [12:0] in_frag_offset;
	logic [3:0] in_header_len;
	logic [31:0] in_src_addr, in_dst_addr;
	logic out_valid, out_hit, last;
	logic f_ipv4, f_mf, f_l4;
	logic [7:0] f_proto, f_ttl;
	logic [12:0] f_off;
	logic [3:0] f_ihl;
	logic [31:0] f_src, f_dst;
	int mismatches, total_checks, frames, hits;

	ipv4_acl_entry_matcher #(.IP_W(32)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .in_valid(in_valid), .in_is_ipv4(in_is_ipv4),
		.in_protocol(in_protocol), .in_ttl(in_ttl),
		.in_more_frags(in_more_frags), .in_frag_offset(in_frag_offset),
		.in_header_len(in_header_len), .in_l4_match(in_l4_match),
		.in_src_addr(in_src_addr), .in_dst_addr(in_dst_addr),
		.out_valid(out_valid), .out_hit(out_hit));

	frame_source u_src (.pclk(pclk), .in_valid(in_valid),
		.in_is_ipv4(in_is_ipv4), .in_protocol(in_protocol), .in_ttl(in_ttl),
		.in_more_frags(in_more_frags), .in_frag_offset(in_frag_offset),
		.in_header_len(in_header_len), .in_l4_match(in_l4_match),
		.in_src_addr(in_src_addr), .in_dst_addr(in_dst_addr));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Values read here are those sampled at this rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic dflt;
		f_ipv4 = 1'b1;
		f_proto = acl_pkg::PROTO_TCP;
		f_ttl = 8'h40;
		f_mf = 1'b0;
		f_off = 13'h0000;
		f_ihl = acl_pkg::IHL_NO_OPTIONS;
		f_l4 = 1'b1;
		f_src = 32'h0a00_0001;
		f_dst = 32'hc0a8_0105;
	endtask : dflt

	// Configure control, send one header, compare the result
	task automatic run(input logic [31:0] ctrl, input logic exp);
		apb(1'b1, acl_pkg::OFS_CTRL, ctrl);
		u_src.send({f_ipv4, f_proto, f_ttl, f_mf, f_off, f_ihl, f_l4,
			f_src, f_dst});
		// Result stands in the cycle after the taking edge only
		@(negedge pclk);
		chk(out_valid, 1'b1);
		chk(out_hit, exp);
		@(negedge pclk);
		chk(out_valid, 1'b0);
		frames++;
		hits += exp;
		last = exp;
		dflt();
	endtask : run

	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		mismatches = 0;
		total_checks = 0;
		frames = 0;
		hits = 0;
		dflt();
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk(e, 1'b0);
			chk(q, 32'h0);
		end
		apb(1'b1, acl_pkg::OFS_CTRL, 32'hffff_ffff);
		apb(1'b0, acl_pkg::OFS_CTRL, 32'h0);
		chk(q, acl_pkg::CTRL_WMASK);
		apb(1'b1, 8'h20, 32'h1234_5678);
		chk(e, 1'b1);
		apb(1'b0, 8'h20, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0);
		apb(1'b1, acl_pkg::OFS_SRC_ADDR, 32'h0a00_0001);
		apb(1'b1, acl_pkg::OFS_SRC_MASK, 32'hffff_ff00);
		apb(1'b1, acl_pkg::OFS_DST_ADDR, 32'hc0a8_0105);
		apb(1'b1, acl_pkg::OFS_DST_MASK, 32'hffff_0000);
		apb(1'b0, acl_pkg::OFS_SRC_MASK, 32'h0);
		chk(q, 32'hffff_ff00);
		$display("test registers done");
		run(32'h1, 1'b1);
		f_ipv4 = 1'b0;
		run(32'h1, 1'b0);
		f_ipv4 = 1'b0;
		run(32'h0, 1'b1);
		run(32'h0006_0003, 1'b1);
		f_proto = 8'h07;
		run(32'h0006_0003, 1'b0);
		f_proto = 8'hff;
		run(32'h00ff_0003, 1'b1);
		run(32'h9, 1'b1);
		f_l4 = 1'b0;
		run(32'h9, 1'b0);
		f_proto = 8'h11;
		run(32'h7, 1'b1);
		run(32'h7, 1'b0);
		f_proto = 8'h01;
		run(32'h5, 1'b1);
		run(32'h5, 1'b0);
		f_ttl = 8'h00;
		run(32'h11, 1'b1);
		run(32'h11, 1'b0);
		f_ttl = 8'h00;
		run(32'h21, 1'b0);
		f_ttl = 8'h01;
		run(32'h21, 1'b1);
		f_mf = 1'b1;
		run(32'h41, 1'b0);
		f_off = 13'h0001;
		run(32'h41, 1'b0);
		run(32'h41, 1'b1);
		f_off = 13'h1fff;
		run(32'h81, 1'b1);
		run(32'h81, 1'b0);
		f_ihl = 4'h6;
		run(32'h101, 1'b0);
		run(32'h101, 1'b1);
		f_ihl = 4'hf;
		run(32'h201, 1'b1);
		run(32'h201, 1'b0);
		run(32'h401, 1'b1);
		f_src = 32'h0a00_0002;
		run(32'h401, 1'b0);
		f_src = 32'h0a00_00fe;
		run(32'h801, 1'b1);
		f_src = 32'h0a00_0101;
		run(32'h801, 1'b0);
		run(32'h1001, 1'b1);
		f_dst = 32'hc0a8_0106;
		run(32'h1001, 1'b0);
		f_dst = 32'hc0a8_ffff;
		run(32'h2001, 1'b1);
		f_dst = 32'hc0a9_0105;
		run(32'h2001, 1'b0);
		f_proto = 8'h2f;
		f_ttl = 8'h00;
		f_mf = 1'b1;
		f_ihl = 4'h9;
		run(32'h3fff, 1'b1);
		run(32'h411, 1'b0);
		f_ttl = 8'h00;
		run(32'h411, 1'b1);
		$display("test matching done");
		apb(1'b0, acl_pkg::OFS_FRAME_CNT, 32'h0);
		chk(q, frames);
		apb(1'b0, acl_pkg::OFS_HIT_CNT, 32'h0);
		chk(q, hits);
		apb(1'b1, acl_pkg::OFS_STATUS, 32'h0);
		apb(1'b0, acl_pkg::OFS_STATUS, 32'h0);
		chk(q, {31'h0, last});
		apb(1'b1, acl_pkg::OFS_HIT_CNT, 32'h0);
		apb(1'b0, acl_pkg::OFS_HIT_CNT, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, acl_pkg::OFS_FRAME_CNT, 32'h0);
		apb(1'b0, acl_pkg::OFS_FRAME_CNT, 32'h0);
		chk(q, 32'h0);
		$display("test counters done");
		give_verdict();
	end
endmodule : ipv4_acl_entry_matcher_tb
